/* File: src/haptic_params.svh */
// constants for the haptic drive control register bank
`ifndef HAPTIC_PARAMS_SVH
`define HAPTIC_PARAMS_SVH
// ----------------------------------------
// bus and register map
// ----------------------------------------
`define DEV_ADDR 7'h2d
`define REG_LOOP_ONE 8'h1b
`define REG_LOOP_TWO 8'h1c
`define LOOP_ONE_RESET 8'h93
`define LOOP_TWO_RESET 8'hda
`define LOOP_ONE_WMASK 8'hbf
// ----------------------------------------
// field positions
// ----------------------------------------
`define BOOST_BIT 7
`define CM_DRIVE_BIT 5
`define DRIVE_MSB 4
`define SIGNED_BIT 7
`define DAMP_BIT 6
`define SAMPLE_MSB 5
`define SAMPLE_LSB 4
`define BLANK_MSB 3
`define BLANK_LSB 2
`define DECAY_MSB 1
// ----------------------------------------
// timing, microseconds at 40 cycles each
// ----------------------------------------
`define CLK_MHZ 40
`define LRA_BASE_US 500
`define LRA_STEP_US 100
`define ERM_BASE_US 1000
`define ERM_STEP_US 200
`define RES_BASE_US 150
`define RES_STEP_US 50
`define HALF_SCALE 10'sd128
`define BYTE_BITS 4'd8
`endif

/* File: src/haptic_pkg.sv */
// types for the haptic drive control register bank
package haptic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WRITE,
    ST_ACK,
    ST_READ,
    ST_MACK
  } bus_state_e;
endpackage

/* File: src/haptic_drive_control_regs.sv */
// two loop control registers behind a two-wire serial slave
// What this block does
// - the boost bit, bit 7 of the first register, resets to 1 and raises overdrive loop gain.
// - the common-mode bit, bit 5, resets to 0 and when set biases the input pin at 0.9 V.
// - in linear mode the 5-bit field, reset 0x13, gives start drive time field*0.1 ms+0.5 ms.
// - in rotating-mass mode the field gives the sampling interval field*0.2 ms+1 ms.
// - bit 7 of the second register, reset 1, selects bidirectional input, 0 unidirectional.
// - unidirectional input maps 0..100% to no..full output, braking from feedback.
// - bidirectional open-loop input below 50% brakes, 50% is silent; closed-loop uses feedback.
// - the damping bit, bit 6 of the second register, reset 1, cuts gain near brake end.
// - the 2-bit sample field, bits 5:4, sets 150, 200, 250 or 300 us tracking periods.
`include "haptic_params.svh"
module haptic_drive_control_regs #(
  parameter int LRA_BASE_CYC = `LRA_BASE_US * `CLK_MHZ,
  parameter int ERM_BASE_CYC = `ERM_BASE_US * `CLK_MHZ,
  parameter int RES_BASE_CYC = `RES_BASE_US * `CLK_MHZ
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic LRA_MODE,
  input wire logic LOOP_CLOSED,
  input wire logic [7:0] INPUT_DUTY,
  output logic OVERDRIVE_GAIN_BOOST,
  output logic INPUT_COMMON_MODE_DRIVE,
  output logic [18:0] DRIVE_TIME_CYC,
  output logic SIGNED_INPUT_SELECT,
  output logic BRAKE_LOOP_DAMPING,
  output logic BRAKE_FROM_FEEDBACK,
  output logic signed [9:0] DRIVE_LEVEL,
  output logic [13:0] RESONANCE_SAMPLE_CYC,
  output logic [1:0] BLANKING_DELAY,
  output logic [1:0] FLYBACK_DECAY_DELAY
);
  import haptic_pkg::*;

  localparam int LRA_STEP_CYC = `LRA_STEP_US * `CLK_MHZ;
  localparam int ERM_STEP_CYC = `ERM_STEP_US * `CLK_MHZ;
  localparam int RES_STEP_CYC = `RES_STEP_US * `CLK_MHZ;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], SCL};
      sda_sync_q <= {sda_sync_q[1:0], SDA_IN};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_now;
  assign sda_now = sda_sync_q[1];
  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  assign bus_start = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
  assign bus_stop = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];

  // ----------------------------------------
  // serial slave and register bank
  // ----------------------------------------
  bus_state_e state_q, state_d;
  bus_state_e after_q, after_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic oe_q, oe_d;
  logic mack_q, mack_d;
  logic [7:0] loop_one_q, loop_one_d;
  logic [7:0] loop_two_q, loop_two_d;
  logic [7:0] rd_data;

  always_comb begin
    case (ptr_q)
      // reserved bit held at zero
      `REG_LOOP_ONE: rd_data = loop_one_q;
      `REG_LOOP_TWO: rd_data = loop_two_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    state_d = state_q;
    after_d = after_q;
    bit_d = bit_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    mack_d = mack_q;
    loop_one_d = loop_one_q;
    loop_two_d = loop_two_q;
    if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      state_d = ST_ADDR;
      bit_d = 4'h0;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WRITE: begin
          shift_d = {shift_q[6:0], sda_now};
          bit_d = bit_q + 4'h1;
        end
        ST_READ: bit_d = bit_q + 4'h1;
        ST_MACK: mack_d = !sda_now;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (bit_q == `BYTE_BITS) begin
            bit_d = 4'h0;
            if (shift_q[7:1] == `DEV_ADDR) begin
              state_d = ST_ACK;
              oe_d = 1'b1;
              after_d = shift_q[0] ? ST_READ : ST_REG;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_REG: begin
          if (bit_q == `BYTE_BITS) begin
            bit_d = 4'h0;
            ptr_d = shift_q;
            state_d = ST_ACK;
            oe_d = 1'b1;
            after_d = ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (bit_q == `BYTE_BITS) begin
            bit_d = 4'h0;
            if (ptr_q == `REG_LOOP_ONE) begin
              loop_one_d = shift_q & `LOOP_ONE_WMASK;
            end
            if (ptr_q == `REG_LOOP_TWO) begin
              loop_two_d = shift_q;
            end
            ptr_d = ptr_q + 8'h01;
            state_d = ST_ACK;
            oe_d = 1'b1;
            after_d = ST_WRITE;
          end
        end
        ST_ACK: begin
          state_d = after_q;
          oe_d = 1'b0;
          if (after_q == ST_READ) begin
            shift_d = {rd_data[6:0], 1'b0};
            oe_d = !rd_data[7];
            ptr_d = ptr_q + 8'h01;
          end
        end
        ST_READ: begin
          if (bit_q == `BYTE_BITS) begin
            bit_d = 4'h0;
            oe_d = 1'b0;
            state_d = ST_MACK;
          end else begin
            oe_d = !shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
          end
        end
        ST_MACK: begin
          if (mack_q) begin
            state_d = ST_READ;
            shift_d = {rd_data[6:0], 1'b0};
            oe_d = !rd_data[7];
            ptr_d = ptr_q + 8'h01;
          end else begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
      loop_one_q <= `LOOP_ONE_RESET;
      loop_two_q <= `LOOP_TWO_RESET;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
      mack_q <= mack_d;
      loop_one_q <= loop_one_d;
      loop_two_q <= loop_two_d;
    end
  end

  // ----------------------------------------
  // settings decoded for the drive engine
  // ----------------------------------------
  logic [18:0] drive_cyc_d;
  logic [13:0] res_cyc_d;
  logic signed [9:0] level_d;
  logic signed [9:0] centred;
  logic [4:0] drive_field;
  logic unidir;

  always_comb begin
    drive_field = loop_one_q[`DRIVE_MSB:0];
    unidir = !loop_two_q[`SIGNED_BIT];
    if (LRA_MODE) begin
      drive_cyc_d = 19'(LRA_BASE_CYC) + 19'(drive_field) * 19'(LRA_STEP_CYC);
    end else begin
      drive_cyc_d = 19'(ERM_BASE_CYC) + 19'(drive_field) * 19'(ERM_STEP_CYC);
    end
    res_cyc_d = 14'(RES_BASE_CYC)
      + 14'(loop_two_q[`SAMPLE_MSB:`SAMPLE_LSB]) * 14'(RES_STEP_CYC);
    centred = 10'(({2'b00, INPUT_DUTY} - `HALF_SCALE) <<< 1);
    if (unidir) begin
      level_d = 10'({1'b0, INPUT_DUTY, 1'b0});
    end else if (LOOP_CLOSED && centred < 10'sd0) begin
      level_d = 10'sd0;
    end else begin
      level_d = centred;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      OVERDRIVE_GAIN_BOOST <= 1'b0;
      INPUT_COMMON_MODE_DRIVE <= 1'b0;
      DRIVE_TIME_CYC <= 19'h0;
      SIGNED_INPUT_SELECT <= 1'b0;
      BRAKE_LOOP_DAMPING <= 1'b0;
      BRAKE_FROM_FEEDBACK <= 1'b0;
      DRIVE_LEVEL <= 10'sh0;
      RESONANCE_SAMPLE_CYC <= 14'h0;
      BLANKING_DELAY <= 2'h0;
      FLYBACK_DECAY_DELAY <= 2'h0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      OVERDRIVE_GAIN_BOOST <= loop_one_q[`BOOST_BIT];
      INPUT_COMMON_MODE_DRIVE <= loop_one_q[`CM_DRIVE_BIT];
      DRIVE_TIME_CYC <= drive_cyc_d;
      SIGNED_INPUT_SELECT <= loop_two_q[`SIGNED_BIT];
      BRAKE_LOOP_DAMPING <= loop_two_q[`DAMP_BIT];
      BRAKE_FROM_FEEDBACK <= unidir || LOOP_CLOSED;
      DRIVE_LEVEL <= level_d;
      RESONANCE_SAMPLE_CYC <= res_cyc_d;
      BLANKING_DELAY <= loop_two_q[`BLANK_MSB:`BLANK_LSB];
      FLYBACK_DECAY_DELAY <= loop_two_q[`DECAY_MSB:0];
      SDA_OUT <= 1'b0;
      SDA_OE <= oe_q;
    end
  end
endmodule

/* File: verification/haptic_drive_control_regs_assertions.sv */
// checker for the haptic drive control register bank
module haptic_regs_chk #(
  parameter int LRA_BASE_CYC = 20000,
  parameter int ERM_BASE_CYC = 40000,
  parameter int RES_BASE_CYC = 6000
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic LRA_MODE,
  input wire logic LOOP_CLOSED,
  input wire logic [7:0] INPUT_DUTY,
  input wire logic OVERDRIVE_GAIN_BOOST,
  input wire logic INPUT_COMMON_MODE_DRIVE,
  input wire logic [18:0] DRIVE_TIME_CYC,
  input wire logic SIGNED_INPUT_SELECT,
  input wire logic BRAKE_LOOP_DAMPING,
  input wire logic BRAKE_FROM_FEEDBACK,
  input wire logic signed [9:0] DRIVE_LEVEL,
  input wire logic [13:0] RESONANCE_SAMPLE_CYC
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_rst;
    $rose(RST_N) |=> OVERDRIVE_GAIN_BOOST && !INPUT_COMMON_MODE_DRIVE && SIGNED_INPUT_SELECT
      && BRAKE_LOOP_DAMPING && RESONANCE_SAMPLE_CYC == RES_BASE_CYC + 2000;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset decode");
  property p_lra;
    $past(RST_N) && $past(LRA_MODE) |-> (DRIVE_TIME_CYC - LRA_BASE_CYC) % 4000 == 0
      && DRIVE_TIME_CYC <= LRA_BASE_CYC + 124000;
  endproperty
  a_lra: assert property (p_lra) else $error("bad linear drive time");
  property p_erm;
    $past(RST_N) && !$past(LRA_MODE) |-> (DRIVE_TIME_CYC - ERM_BASE_CYC) % 8000 == 0
      && DRIVE_TIME_CYC <= ERM_BASE_CYC + 248000;
  endproperty
  a_erm: assert property (p_erm) else $error("bad sampling interval");
  property p_smp;
    $past(RST_N) |-> (RESONANCE_SAMPLE_CYC - RES_BASE_CYC) % 2000 == 0
      && RESONANCE_SAMPLE_CYC <= RES_BASE_CYC + 6000;
  endproperty
  a_smp: assert property (p_smp) else $error("bad tracking period");
  property p_uni;
    $past(RST_N) && !SIGNED_INPUT_SELECT |-> DRIVE_LEVEL == 2 * $past(INPUT_DUTY);
  endproperty
  a_uni: assert property (p_uni) else $error("bad unsigned level");
  property p_bid;
    $past(RST_N) && SIGNED_INPUT_SELECT && !$past(LOOP_CLOSED)
      |-> DRIVE_LEVEL == $signed({2'b0, $past(INPUT_DUTY)}) * 2 - 256;
  endproperty
  a_bid: assert property (p_bid) else $error("bad signed level");
  property p_clo;
    $past(RST_N) && SIGNED_INPUT_SELECT && $past(LOOP_CLOSED) && $past(INPUT_DUTY) < 8'h80
      |-> DRIVE_LEVEL == 0;
  endproperty
  a_clo: assert property (p_clo) else $error("closed loop brake level");
  property p_brk;
    $past(RST_N) |-> BRAKE_FROM_FEEDBACK == (!SIGNED_INPUT_SELECT || $past(LOOP_CLOSED));
  endproperty
  a_brk: assert property (p_brk) else $error("bad brake source");
endmodule
bind haptic_drive_control_regs haptic_regs_chk #(.LRA_BASE_CYC(LRA_BASE_CYC),
  .ERM_BASE_CYC(ERM_BASE_CYC), .RES_BASE_CYC(RES_BASE_CYC)) chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .LRA_MODE(LRA_MODE), .LOOP_CLOSED(LOOP_CLOSED), .INPUT_DUTY(INPUT_DUTY),
  .OVERDRIVE_GAIN_BOOST(OVERDRIVE_GAIN_BOOST), .INPUT_COMMON_MODE_DRIVE(INPUT_COMMON_MODE_DRIVE),
  .DRIVE_TIME_CYC(DRIVE_TIME_CYC), .SIGNED_INPUT_SELECT(SIGNED_INPUT_SELECT),
  .BRAKE_LOOP_DAMPING(BRAKE_LOOP_DAMPING), .BRAKE_FROM_FEEDBACK(BRAKE_FROM_FEEDBACK),
  .DRIVE_LEVEL(DRIVE_LEVEL), .RESONANCE_SAMPLE_CYC(RESONANCE_SAMPLE_CYC));

/* File: verification/haptic_host_model.sv */
// host side two-wire master model
`include "haptic_params.svh"
module haptic_host_model (
  input wire logic CLOCK,
  input wire logic SDA_OE,
  output logic SCL,
  output wire logic SDA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b1;
  int nacks = 0;
  initial SCL = 1'b1;
  // released line is pulled high
  assign SDA = SDA_OE ? 1'b0 : drv;
  task automatic hc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic bit_io(input logic b, output logic r);
    hc(3);
    drv <= b;
    hc(7);
    SCL <= 1'b1;
    hc(10);
    r = SDA;
    SCL <= 1'b0;
  endtask
  task automatic start();
    hc(3);
    drv <= 1'b1;
    hc(7);
    SCL <= 1'b1;
    hc(10);
    drv <= 1'b0;
    hc(10);
    SCL <= 1'b0;
  endtask
  task automatic stop();
    hc(3);
    drv <= 1'b0;
    hc(7);
    SCL <= 1'b1;
    hc(10);
    drv <= 1'b1;
    hc(10);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    xfer(d, 1'b1, q, a);
    if (a !== 1'b0) nacks++;
  endtask
  task automatic head(input logic [7:0] r);
    start();
    send({`DEV_ADDR, 1'b0});
    send(r);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    head(r);
    send(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] q);
    logic a;
    head(r);
    start();
    send({`DEV_ADDR, 1'b1});
    // master nack ends the read
    xfer(8'hff, 1'b1, q, a);
    stop();
  endtask
  task automatic wr2(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1);
    head(r);
    send(d0);
    send(d1);
    stop();
  endtask
  task automatic rd2(input logic [7:0] r, output logic [7:0] q0, output logic [7:0] q1);
    logic a;
    head(r);
    start();
    send({`DEV_ADDR, 1'b1});
    // master ack asks for the next register
    xfer(8'hff, 1'b0, q0, a);
    xfer(8'hff, 1'b1, q1, a);
    stop();
  endtask
  task automatic probe(input logic [6:0] adr, output logic a);
    logic [7:0] q;
    start();
    xfer({adr, 1'b0}, 1'b1, q, a);
    stop();
  endtask
endmodule

/* File: verification/haptic_drive_control_regs_tb.sv */
// testbench for the haptic drive control register bank
module haptic_drive_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic lra = 1'b1;
  logic closed = 1'b1;
  logic [7:0] duty = 8'h00;
  wire scl;
  wire sda;
  logic sda_oe, boost, cm, sgn, damp, bfb;
  logic [18:0] dtc;
  logic signed [9:0] lvl;
  logic [13:0] rsc;
  logic sda_out, nak;
  logic [1:0] blank, decay;
  int error_cnt = 0;
  int checks_done = 0;
  int dt[3] = '{0, 128, 255};
  always #12.5 CLOCK = ~CLOCK;
  haptic_drive_control_regs #(.LRA_BASE_CYC(40), .ERM_BASE_CYC(80), .RES_BASE_CYC(12)) uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .LRA_MODE(lra), .LOOP_CLOSED(closed), .INPUT_DUTY(duty), .OVERDRIVE_GAIN_BOOST(boost),
    .INPUT_COMMON_MODE_DRIVE(cm), .DRIVE_TIME_CYC(dtc), .SIGNED_INPUT_SELECT(sgn),
    .BRAKE_LOOP_DAMPING(damp), .BRAKE_FROM_FEEDBACK(bfb), .DRIVE_LEVEL(lvl),
    .RESONANCE_SAMPLE_CYC(rsc), .BLANKING_DELAY(blank), .FLYBACK_DECAY_DELAY(decay));
  haptic_host_model host (.CLOCK(CLOCK), .SDA_OE(sda_oe), .SCL(scl), .SDA(sda));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.rd(a, q);
    chk("register", e, q);
  endtask
  task automatic rd2_chk(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q0;
    logic [7:0] q1;
    host.rd2(a, q0, q1);
    chk("register", e0, q0);
    chk("next register", e1, q1);
  endtask
  task automatic setd(input int d);
    duty <= 8'(d);
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    chk("boost", 1, boost);
    chk("cm", 0, cm);
    chk("drive", 40 + 19 * 4000, dtc);
    lra <= 1'b0;
    repeat (3) @(posedge CLOCK);
    chk("drive", 80 + 19 * 8000, dtc);
    chk("signed", 1, sgn);
    chk("damp", 1, damp);
    chk("sample", 12 + 2000, rsc);
    chk("blank", 2, blank);
    chk("decay", 2, decay);
    chk("sda out", 0, sda_out);
    rd_chk(8'h1b, 8'h93);
    rd_chk(8'h1c, 8'hda);
    host.wr(8'h1b, 8'hff);
    rd_chk(8'h1b, 8'hbf);
    chk("cm", 1, cm);
    chk("drive", 80 + 31 * 8000, dtc);
    lra <= 1'b1;
    host.wr(8'h1b, 8'h40);
    chk("boost", 0, boost);
    chk("drive", 40, dtc);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h1c, 8'(k * 16));
      chk("sample", 12 + k * 2000, rsc);
      rd_chk(8'h1c, 8'(k * 16));
    end
    chk("signed", 0, sgn);
    chk("damp", 0, damp);
    for (int k = 0; k < 3; k++) begin
      setd(dt[k]);
      chk("level", 2 * dt[k], 32'(lvl));
      chk("brake", 1, bfb);
    end
    host.wr(8'h1c, 8'hc0);
    // open loop is only used with signed input
    closed <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      setd(dt[k]);
      chk("level", 2 * dt[k] - 256, 32'(lvl));
      chk("brake", 0, bfb);
    end
    closed <= 1'b1;
    setd(64);
    chk("level", 0, 32'(lvl));
    setd(192);
    chk("level", 128, 32'(lvl));
    chk("brake", 1, bfb);
    // start drive time of half a 4 ms resonance period
    host.wr2(8'h1b, 8'h8f, 8'hc6);
    chk("drive", 40 + 15 * 4000, dtc);
    chk("boost", 1, boost);
    chk("sample", 12, rsc);
    chk("blank", 1, blank);
    chk("decay", 2, decay);
    host.wr(8'h1d, 8'h55);
    rd2_chk(8'h1b, 8'h8f, 8'hc6);
    rd_chk(8'h1d, 8'h00);
    host.probe(7'h2c, nak);
    chk("nack", 1, nak);
    chk("sda out", 0, sda_out);
    chk("nacks", 0, host.nacks);
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge CLOCK);
    error_cnt++;
    end_sim();
  end
endmodule
